//--- rtl/acv_ctrl.sv
// Converter control, status and result readout logic
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Edge start mode: flag end of conversion
// - Busy holds host waiting during first read
// - Wait only on first byte read
// - Gated clock: serial pins idle between conversions
// - Data valid on first falling serial edge
// - Shift result as sixteen-bit word during conversion
// - Continuous clock: drive frame marker strobe
// - Busy rising edge latches parallel outputs
// - Busy low throughout select-started conversion
// - Edge mode: status low at end, cleared by read
// - Parallel format returns twelve bits at once
module acv_ctrl
	import acv_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYC
) (
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst_b,
	// Host pins (asynchronous)
	input  wire logic                conversion_trigger_n,
	input  wire logic                chip_select_n,
	input  wire logic                read_n,
	input  wire logic                upper_byte_select,
	// Configuration
	input  wire logic [1:0]          output_format,
	input  wire logic                select_start_mode,
	// Analog core result source
	input  wire logic [RES_W-1:0]    sample_code,
	// Status and parallel outputs
	output logic                     busy_or_eoc_n,
	output logic [RES_W-1:0]         parallel_result_bus,
	// Serial outputs (open drain: drive low when oe high)
	output logic                     serial_clock_oe,
	output logic                     serial_result_line_oe,
	output logic                     serial_frame_marker_n_oe,
	// Buffered results
	output logic                     result_valid,
	input  wire logic                result_ready,
	output logic [RES_W-1:0]         result_data
);
	import acv_pkg::*;
	initial
	begin
		if (CONV_CYCLES < WORD_W * SCLK_DIV)
			$error("Conversion too short for serial word");
	end
	typedef struct packed
	{
		logic [2:0]         sy_trig;
		logic [2:0]         sy_cs;
		logic [2:0]         sy_rd;
		logic [1:0]         sy_hb;
		acv_state_t         state;
		logic [15:0]        cnt;
		logic [3:0]         div;
		logic [4:0]         bitn;
		logic [WORD_W-1:0]  shreg;
		logic [RES_W-1:0]   result;
		logic               stat_n;
		logic [RES_W-1:0]   pbus;
		logic               first_done;
		logic               sclk;
		logic               sdat;
		logic               sfrm;
		logic               push;
	} acv_st_t;
	acv_st_t st_ff;
	acv_st_t nxt_st;
	logic    trig_fall;
	logic    cs_fall;
	logic    rd_act;
	logic    rdcs_fall;
	logic    fifo_ready;
	logic    serial_fmt;
	assign trig_fall  = st_ff.sy_trig[2] && !st_ff.sy_trig[1];
	assign cs_fall    = st_ff.sy_cs[2] && !st_ff.sy_cs[1];
	assign rd_act     = !st_ff.sy_cs[1] && !st_ff.sy_rd[1];
	assign rdcs_fall  = rd_act && !(!st_ff.sy_cs[2] && !st_ff.sy_rd[2]);
	assign serial_fmt = output_format != FMT_PARALLEL;
	always_comb
	begin
		nxt_st         = st_ff;
		nxt_st.sy_trig = {st_ff.sy_trig[1:0], conversion_trigger_n};
		nxt_st.sy_cs   = {st_ff.sy_cs[1:0], chip_select_n};
		nxt_st.sy_rd   = {st_ff.sy_rd[1:0], read_n};
		nxt_st.sy_hb   = {st_ff.sy_hb[0], upper_byte_select};
		nxt_st.push    = 1'b0;
		unique case (st_ff.state)
			ST_IDLE:
			begin
				// Select start needs upper byte select low, as on the pin
				if ((!select_start_mode && trig_fall)
					|| (select_start_mode && cs_fall && !st_ff.sy_hb[1]))
				begin
					nxt_st.state  = ST_CONV;
					nxt_st.cnt    = '0;
					nxt_st.div    = '0;
					nxt_st.bitn   = '0;
					nxt_st.shreg  = {{(WORD_W-RES_W){1'b0}}, sample_code};
					nxt_st.result = sample_code;
					nxt_st.first_done = 1'b0;
					if (select_start_mode)
						nxt_st.stat_n = 1'b0;
					else
						nxt_st.stat_n = 1'b1;
				end
			end
			ST_CONV:
			begin
				nxt_st.cnt = st_ff.cnt + 16'h0001;
				if (serial_fmt && st_ff.bitn < 5'(WORD_W))
				begin
					nxt_st.div = st_ff.div + 4'h1;
					if (st_ff.div == 4'(SCLK_DIV/2 - 1))
					begin
						// Falling edge with data already stable beforehand
						nxt_st.sclk = 1'b0;
					end
					else if (st_ff.div == 4'(SCLK_DIV - 1))
					begin
						nxt_st.div   = '0;
						nxt_st.sclk  = 1'b1;
						nxt_st.bitn  = st_ff.bitn + 5'h01;
						nxt_st.shreg = {st_ff.shreg[WORD_W-2:0], 1'b0};
					end
					nxt_st.sdat = st_ff.shreg[WORD_W-1];
					nxt_st.sfrm = output_format == FMT_SERIAL_CONT;
				end
				else
				begin
					// Released high unless the clock runs free
					nxt_st.sfrm = 1'b0;
					nxt_st.sclk = output_format != FMT_SERIAL_CONT || st_ff.div[2];
					nxt_st.div  = st_ff.div + 4'h1;
				end
				if (st_ff.cnt == 16'(CONV_CYCLES - 1))
				begin
					nxt_st.state  = ST_DONE;
					nxt_st.stat_n = select_start_mode;
					nxt_st.push   = 1'b1;
					// Busy rises with the result already on the bus
					nxt_st.pbus   = st_ff.result;
					nxt_st.sfrm   = 1'b0;
					nxt_st.sclk   = 1'b1;
					nxt_st.sdat   = 1'b1;
				end
			end
			ST_DONE:
			begin
				if (!select_start_mode && rdcs_fall)
					nxt_st.stat_n = 1'b1;
				if (output_format == FMT_PARALLEL)
					nxt_st.pbus = st_ff.result;
				else if (st_ff.sy_hb[1])
					nxt_st.pbus = {4'h0, 4'h0, st_ff.result[11:8]};
				else
					nxt_st.pbus = {4'h0, st_ff.result[7:0]};
				// Second byte read completes without any wait
				if (rdcs_fall)
					nxt_st.first_done = 1'b1;
				if ((!select_start_mode && trig_fall)
					|| (select_start_mode && cs_fall && st_ff.first_done
						&& !st_ff.sy_hb[1]))
					nxt_st.state = ST_IDLE;
			end
			default:
				nxt_st.state = ST_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_ff        <= '0;
			st_ff.sy_trig <= 3'h7;
			st_ff.sy_cs  <= 3'h7;
			st_ff.sy_rd  <= 3'h7;
			st_ff.state  <= ST_IDLE;
			st_ff.stat_n <= 1'b1;
			st_ff.sclk   <= 1'b1;
			st_ff.sdat   <= 1'b1;
			st_ff.pbus   <= RESULT_RST;
			st_ff.result <= RESULT_RST;
		end
		else
			st_ff <= nxt_st;
	end
	// Results are also queued; a stalled drain simply drops new results
	acv_fifo #(
		.WIDTH (RES_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.in_valid  (st_ff.push),
		.in_ready  (fifo_ready),
		.in_data   (st_ff.pbus),
		.out_valid (result_valid),
		.out_ready (result_ready),
		.out_data  (result_data)
	);
	// Busy with chip select forms the wait for the first read
	assign busy_or_eoc_n            = st_ff.stat_n;
	assign parallel_result_bus      = st_ff.pbus;
	assign serial_clock_oe          = !st_ff.sclk;
	assign serial_result_line_oe    = !st_ff.sdat;
	assign serial_frame_marker_n_oe = st_ff.sfrm;
	a_busy_low_conv: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_ff.state == ST_CONV && select_start_mode) |-> !busy_or_eoc_n)
		else $error("busy high during conversion");
	a_eoc_on_done: assert property (@(posedge sys_clk) disable iff (!rst_b)
		($rose(st_ff.state == ST_DONE) && !select_start_mode) |-> !busy_or_eoc_n)
		else $error("end flag not low at completion");
	a_eoc_clear_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_ff.state == ST_DONE && !select_start_mode && rdcs_fall) |=> busy_or_eoc_n)
		else $error("end flag not cleared by read");
	a_serial_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_ff.state == ST_IDLE && output_format == FMT_SERIAL_GATED)
		|-> (!serial_clock_oe && !serial_result_line_oe))
		else $error("serial pins active while idle");
	a_frame_cont: assert property (@(posedge sys_clk) disable iff (!rst_b)
		serial_frame_marker_n_oe |-> st_ff.state == ST_CONV)
		else $error("frame marker outside conversion");
	a_par_word: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(st_ff.state == ST_DONE) |-> parallel_result_bus == st_ff.result)
		else $error("result not on bus when busy rises");
	a_full_word: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_ff.state == ST_DONE && output_format == FMT_PARALLEL)
		|=> parallel_result_bus == $past(st_ff.result))
		else $error("parallel read not full word");
	a_conv_len: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(st_ff.state == ST_CONV) |-> (st_ff.state == ST_CONV)[*8])
		else $error("conversion ended too early");
endmodule : acv_ctrl
`default_nettype wire

//--- rtl/acv_pkg.sv
// Package of constants for the converter control and readout block
package acv_pkg;
	localparam int RES_W         = 12;
	localparam int WORD_W        = 16;
	localparam int CLK_HZ        = 25_000_000;
	localparam int CONV_NS       = 8000;
	localparam int CONV_CYC      = (CONV_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int SCLK_DIV      = 10;
	localparam int FIFO_DEPTH    = 16;
	localparam logic [1:0] FMT_SERIAL_GATED = 2'h0;
	localparam logic [1:0] FMT_SERIAL_CONT  = 2'h1;
	localparam logic [1:0] FMT_PARALLEL     = 2'h2;
	localparam logic [11:0] RESULT_RST      = 12'h000;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_CONV = 3'b010,
		ST_DONE = 3'b100
	} acv_state_t;
endpackage : acv_pkg

//--- rtl/acv_fifo.sv
// Result FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module acv_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed
	{
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
	} acv_fifo_st_t;
	acv_fifo_st_t st_ff;
	acv_fifo_st_t nxt_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;
	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("FIFO depth must be a power of two");
	end
	assign out_valid = st_ff.wr_ptr != st_ff.rd_ptr;
	assign in_ready  = !((st_ff.wr_ptr[AW] != st_ff.rd_ptr[AW])
		&& (st_ff.wr_ptr[AW-1:0] == st_ff.rd_ptr[AW-1:0]));
	assign out_data  = mem[st_ff.rd_ptr[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	always_comb
	begin
		nxt_st = st_ff;
		if (push)
			nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
		if (pop)
			nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
	end
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[st_ff.wr_ptr[AW-1:0]] <= in_data;
	end
endmodule : acv_fifo
`default_nettype wire

//--- testbench/acv_host_rx.sv
// Host serial port model that collects one word per conversion
`timescale 1ns/1ns
`default_nettype none
module acv_host_rx (
	// Clock and clear
	input  wire logic   sys_clk,
	input  wire logic   clr,
	// Open-drain pins, pulled up on the board
	input  wire logic   sclk_oe,
	input  wire logic   sdat_oe,
	input  wire logic   mark_oe,
	// Received word and counts
	output logic [15:0] word,
	output int          bits,
	output int          marks
);
	logic sclk_q = 1'b1;
	always @(posedge sys_clk)
	begin
		sclk_q <= ~sclk_oe;
		if (clr)
		begin
			bits <= 0;
			marks <= 0;
			word <= 16'h0000;
		end
		else
		begin
			// No frame strobe used: the first clock fall already carries data
			if (sclk_q && sclk_oe)
			begin
				word <= {word[14:0], ~sdat_oe};
				bits <= bits + 1;
			end
			if (mark_oe)
				marks <= marks + 1;
		end
	end
endmodule : acv_host_rx
`default_nettype wire

//--- testbench/acv_ctrl_tb_top.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module acv_ctrl_tb_top;
	import acv_pkg::*;
	logic             sys_clk = 1'b0;
	logic             rst_b = 1'b0;
	logic             trig_n = 1'b1;
	logic             cs_n = 1'b1;
	logic             rd_n = 1'b1;
	logic             ube = 1'b0;
	logic             sel = 1'b0;
	logic             rdy = 1'b0;
	logic             clr = 1'b1;
	logic [1:0]       fmt = FMT_PARALLEL;
	logic [RES_W-1:0] code = 12'h000;
	logic             eoc_n, rv, sclk_oe, sdat_oe, mark_oe;
	logic [RES_W-1:0] pbus, rdata;
	logic [RES_W-1:0] got_q[$];
	logic [15:0]      word;
	int               bits, marks;
	int               bad_count = 0;
	int               checks = 0;
	always #20 sys_clk = ~sys_clk;
	acv_ctrl #(.CONV_CYCLES(160)) u_acv_ctrl (.sys_clk(sys_clk), .rst_b(rst_b),
		.conversion_trigger_n(trig_n), .chip_select_n(cs_n), .read_n(rd_n),
		.upper_byte_select(ube), .output_format(fmt), .select_start_mode(sel),
		.sample_code(code), .busy_or_eoc_n(eoc_n), .parallel_result_bus(pbus),
		.serial_clock_oe(sclk_oe), .serial_result_line_oe(sdat_oe),
		.serial_frame_marker_n_oe(mark_oe), .result_valid(rv),
		.result_ready(rdy), .result_data(rdata));
	acv_host_rx u_acv_host_rx (.sys_clk(sys_clk), .clr(clr), .sclk_oe(sclk_oe),
		.sdat_oe(sdat_oe), .mark_oe(mark_oe), .word(word), .bits(bits),
		.marks(marks));
	always @(posedge sys_clk)
		if (rv === 1'b1 && rdy === 1'b1)
			got_q.push_back(rdata);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Edge mode waits for the end flag, select mode for busy to rise
	task automatic wait_end();
		int n;
		n = 0;
		while (eoc_n !== sel && n < 400)
		begin
			@(negedge sys_clk);
			n++;
		end
		chk(16'(n < 400), 16'h0001);
	endtask : wait_end
	// Two edges: a finished converter needs one to leave its done state
	task automatic start_conv();
		repeat (2)
		begin
			@(posedge sys_clk) trig_n <= 1'b0;
			repeat (4) @(posedge sys_clk);
			trig_n <= 1'b1;
			repeat (6) @(posedge sys_clk);
		end
		wait_end();
	endtask : start_conv
	task automatic rd_cycle(input logic u, output logic [RES_W-1:0] v);
		@(posedge sys_clk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		ube <= u;
		// Byte select needs its synchroniser and one bus update
		repeat (4) @(negedge sys_clk);
		v = pbus;
		@(posedge sys_clk);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		ube <= 1'b0;
		repeat (3) @(negedge sys_clk);
	endtask : rd_cycle
	task automatic tally_and_finish();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		logic [RES_W-1:0] v;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		clr <= 1'b0;
		repeat (3) @(negedge sys_clk);
		chk(16'({eoc_n, sclk_oe, sdat_oe, mark_oe, rv}), 16'h0010);
		// Far side stalls while the FIFO overfills
		for (int i = 0; i < FIFO_DEPTH + 2; i++)
		begin
			@(posedge sys_clk) code <= 12'h0F0 + 12'(i);
			start_conv();
			chk(16'(eoc_n), 16'h0000);
			chk(16'(pbus), 16'(code));
			rd_cycle(1'b0, v);
			chk(16'(eoc_n), 16'h0001);
		end
		@(posedge sys_clk) rdy <= 1'b1;
		repeat (40) @(negedge sys_clk);
		chk(16'(got_q.size()), 16'(FIFO_DEPTH));
		for (int i = 0; i < FIFO_DEPTH; i++)
			chk(16'(got_q[i]), 16'h00F0 + 16'(i));
		chk(16'(rv), 16'h0000);
		for (int f = 0; f < 2; f++)
		begin
			@(posedge sys_clk);
			fmt <= 2'(f);
			code <= 12'hA53 + 12'(f);
			clr <= 1'b1;
			@(posedge sys_clk) clr <= 1'b0;
			@(negedge sys_clk);
			if (f == 0)
				chk(16'({sclk_oe, sdat_oe}), 16'h0000);
			start_conv();
			if (f == 0)
			begin
				chk(16'(bits), 16'(WORD_W));
				chk(word, {4'h0, code});
			end
			else
				chk(16'(marks > 0), 16'h0001);
			rd_cycle(1'b0, v);
		end
		@(posedge sys_clk);
		sel <= 1'b1;
		fmt <= FMT_SERIAL_GATED;
		code <= 12'h5C3;
		rd_cycle(1'b0, v);
		// Select held past the conversion, read pending throughout
		@(posedge sys_clk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		repeat (8) @(negedge sys_clk);
		chk(16'(eoc_n), 16'h0000);
		wait_end();
		// Whole word stands in the cycle busy rises
		chk(16'(pbus), 16'(code));
		@(posedge sys_clk);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		rd_cycle(1'b1, v);
		chk(16'(v), 16'(code[11:8]));
		chk(16'(eoc_n), 16'h0001);
		tally_and_finish();
	end
	// About 4k cycles needed; allow five times that
	initial
	begin
		#(40 * 20000);
		bad_count++;
		tally_and_finish();
	end
endmodule : acv_ctrl_tb_top
`default_nettype wire
